// *** src/dkar_pkg.sv ***
// constants, field layouts and carrier types for the display/keypad/alarm block
// assumes one 100 MHz clock shared by every user of this package
package dkar_pkg;
  // data width of every display and configuration register (six bcd digits)
  localparam int DW = 24;

  // key codes from the display unit: 00..09 digits, 10..17 the eight view keys
  localparam logic [4:0] KEY_DIG_LAST = 5'h09;
  localparam logic [4:0] KEY_SEL0     = 5'h10;
  localparam logic [4:0] KEY_SEL7     = 5'h17;
  localparam logic [4:0] KEY_EQ       = 5'h18;
  localparam logic [4:0] KEY_CFG      = 5'h19;
  localparam logic [4:0] KEY_TEST     = 5'h1A;

  // lead digit characters
  localparam logic [7:0] CH_BLANK = 8'h20;
  localparam logic [7:0] CH_ALARM = 8'h41;
  localparam logic [7:0] CH_DIG1  = 8'h31;

  // byte offsets on the register bus
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_ERR    = 8'h08;
  localparam logic [7:0] A_DISP   = 8'h20;
  localparam logic [7:0] A_CFG    = 8'h40;

  // display register numbers, shown to the user as one to eight
  localparam logic [2:0] R_FLOW   = 3'h0;
  localparam logic [2:0] R_TCFLOW = 3'h1;
  localparam logic [2:0] R_TEMP   = 3'h2;
  localparam logic [2:0] R_SPARE  = 3'h3;
  localparam logic [2:0] R_TOTAL  = 3'h4;
  localparam logic [2:0] R_BATCH  = 3'h5;
  localparam logic [2:0] R_SETPOINT_VALUE   = 3'h6;
  localparam logic [2:0] R_INST   = 3'h7;

  // function fields inside configuration register one
  localparam int         CFG_OUT3_LSB = 0;
  localparam int         CFG_IN_LSB   = 4;
  localparam logic [1:0] O3_PULSE     = 2'h0;
  localparam logic [1:0] O3_BUS       = 2'h1;
  localparam logic [1:0] O3_CURR      = 2'h2;
  localparam logic [1:0] IF_NONE      = 2'h0;
  localparam logic [1:0] IF_STOP      = 2'h1;
  localparam logic [1:0] IF_BATCH     = 2'h2;
  localparam logic [1:0] IF_MANUAL    = 2'h3;
  localparam logic [DW-1:0] CFG_RST   = 24'h000000;

  // control and status bit positions
  localparam int CTRL_OUT3_LVL = 0;
  localparam int ST_ALARM      = 0;
  localparam int ST_INPUT      = 1;
  localparam int ST_MANUAL     = 2;
  localparam int ST_STOP       = 3;
  localparam int ST_VIEW_LSB   = 8;
  localparam int ST_SEL_LSB    = 16;
  localparam int ST_CSEL_LSB   = 20;

  // timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int BLANK_MS       = 1000;
  localparam int REFRESH_MS     = 1000;
  localparam int PULSE_MAX_HZ   = 1000;
  localparam int BLANK_CYC      = CLK_HZ / 1000 * BLANK_MS;
  localparam int REFRESH_CYC    = CLK_HZ / 1000 * REFRESH_MS;
  localparam int PULSE_HALF_CYC = CLK_HZ / (2 * PULSE_MAX_HZ);

  typedef enum logic [4:0] {
    V_SHOW  = 5'b00001,
    V_BLANK = 5'b00010,
    V_CFGW  = 5'b00100,
    V_CFG   = 5'b01000,
    V_ERR   = 5'b10000
  } dkar_view_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] code;
  } dkar_key_t;

  typedef struct packed {
    logic          update;
    logic          blank;
    logic [7:0]    lead;
    logic [DW-1:0] value;
  } dkar_disp_t;

  typedef struct packed {
    logic [DW-1:0] flow;
    logic [DW-1:0] tcflow;
    logic [DW-1:0] temp;
    logic [DW-1:0] instant;
  } dkar_meas_t;
endpackage

// *** src/dkar_sync.sv ***
// two-stage synchroniser for levels arriving from outside the clock domain
// assumes the level is slow against hclk; only the second stage is read
module dkar_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // level in and out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** src/dkar_pulse.sv ***
// volume pulse former for the fast digital output
// assumes requests are single-cycle; up to 255 queue, so bursts within that depth are not lost
module dkar_pulse #(
  parameter int HALF_CYC = 50000
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic enable,
  input  wire logic req,
  output logic      level
);
  logic [7:0]  pending;
  logic [31:0] cnt;
  logic        busy;
  logic        half_end;

  assign half_end = (cnt == 32'(HALF_CYC - 1));

  // each pulse is high for one half period then low for one, capping the rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= 8'h00;
      cnt     <= 32'h0;
      busy    <= 1'b0;
      level   <= 1'b0;
    end else if (!enable) begin
      pending <= 8'h00;
      cnt     <= 32'h0;
      busy    <= 1'b0;
      level   <= 1'b0;
    end else begin
      if (!busy && pending != 8'h00) begin
        busy    <= 1'b1;
        level   <= 1'b1;
        cnt     <= 32'h0;
        pending <= pending - 8'h01 + {7'h00, req};
      end else begin
        // saturate rather than wrap when flow outruns the output
        if (req && pending != 8'hFF)
          pending <= pending + 8'h01;
        if (busy) begin
          cnt <= half_end ? 32'h0 : cnt + 32'h1;
          if (half_end && level)
            level <= 1'b0;
          else if (half_end)
            busy <= 1'b0;
        end
      end
    end
  end
endmodule

// *** src/dkar_top.sv ***
// display, keypad and alarm readout logic of the flow transmitter, with register access over ahb-lite
// assumes keys and measurements come from logic on hclk; the logic input line is asynchronous
module dkar_top
  import dkar_pkg::*;
#(
  parameter int BLANK_CYC      = dkar_pkg::BLANK_CYC,
  parameter int REFRESH_CYC    = dkar_pkg::REFRESH_CYC,
  parameter int PULSE_HALF_CYC = dkar_pkg::PULSE_HALF_CYC
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // display unit
  input  wire dkar_pkg::dkar_key_t  key,
  output dkar_pkg::dkar_disp_t      disp,
  // measurement side
  input  wire dkar_pkg::dkar_meas_t meas,
  input  wire logic                 vol_tick,
  input  wire logic [7:0]           err_code,
  // pins and function outputs
  input  wire logic                 logic_input_line,
  output logic                      pulse_or_current_output,
  output logic                      out3_digital_en,
  output logic                      current_loop_en,
  output logic      [15:0]          current_level,
  output logic                      batch_start,
  output logic                      pi_manual
);
  import dkar_pkg::*;

  // view state and keypad entry
  dkar_view_t    view;
  logic [2:0]    sel;
  logic [2:0]    csel;
  logic [DW-1:0] entry;
  logic          entering;
  logic [31:0]   blank_tmr;
  logic [31:0]   ref_tmr;
  logic          ref_tick;
  logic          reload;
  // storage
  logic [DW-1:0] spare;
  logic [DW-1:0] total_volume;
  logic [DW-1:0] batch_volume;
  logic [DW-1:0] setpoint_value;
  logic [DW-1:0] cfg [8];
  logic [31:0]   ctrl;
  // alarm
  logic          alarm_lat;
  logic [7:0]    lat_code;
  logic [7:0]    shown_code;
  logic          err_now;
  // input and bus
  logic          input_sync;
  logic          input_prev;
  logic          pulse_lvl;
  logic          wr_pend;
  logic          rd_pend;
  logic [31:0]   wr_addr;
  logic [31:0]   rd_addr;
  logic          addr_ok;
  // key and write decode
  logic          k_take;
  logic          k_digit;
  logic          k_sel;
  logic          kw_disp;
  logic          kw_cfg;
  logic          bw_disp;
  logic          bw_cfg;
  logic [2:0]    bw_idx;
  logic [1:0]    o3_mode;
  logic [1:0]    in_func;
  logic          count_stop;
  logic          batch_edge;

  // mode decode: a reserved output code falls back to pulse
  // a function for the output mode only; the input field is read directly
  function automatic logic [1:0] out3_of(input logic [DW-1:0] c);
    logic [1:0] m;
    m = c[CFG_OUT3_LSB +: 2];
    return (m == O3_BUS || m == O3_CURR) ? m : O3_PULSE;
  endfunction

  // display register read, numbered from zero
  // register order
  function automatic logic [DW-1:0] disp_val(input logic [2:0] i);
    logic [DW-1:0] v;
    v = '0;
    unique case (i)
      R_FLOW:   v = meas.flow;
      R_TCFLOW: v = meas.tcflow;
      R_TEMP:   v = meas.temp;
      R_SPARE:  v = spare;
      R_TOTAL:  v = total_volume;
      R_BATCH:  v = batch_volume;
      R_SETPOINT_VALUE:   v = setpoint_value;
      R_INST:   v = meas.instant;
    endcase
    return v;
  endfunction

  // true when an address lands in the block of eight words at base
  function automatic logic in_blk(input logic [31:0] a, input logic [7:0] base);
    return a[31:8] == 24'h0 && a[7:5] == base[7:5];
  endfunction

  assign o3_mode    = out3_of(cfg[0]);
  assign in_func    = cfg[0][CFG_IN_LSB +: 2];
  assign err_now    = (err_code != 8'h00);
  assign count_stop = (in_func == IF_STOP) && input_sync;
  assign batch_edge = (in_func == IF_BATCH) && input_sync && !input_prev;

  // key classification; keys are ignored only in V_BLANK, not in V_CFGW where the display is also blanked
  assign k_take  = key.valid && view != V_BLANK;
  assign k_digit = k_take && key.code <= KEY_DIG_LAST;
  assign k_sel   = k_take && key.code >= KEY_SEL0 && key.code <= KEY_SEL7;
  assign kw_disp = k_take && key.code == KEY_EQ && entering && view == V_SHOW;
  assign kw_cfg  = k_take && key.code == KEY_EQ && entering && view == V_CFG;

  // bus write decode, valid in the data phase
  assign bw_idx  = wr_addr[4:2];
  assign bw_disp = wr_pend && in_blk(wr_addr, A_DISP);
  assign bw_cfg  = wr_pend && in_blk(wr_addr, A_CFG);
  assign addr_ok = (haddr[1:0] == 2'b00);

  dkar_sync #(.W(1)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (logic_input_line),
    .sync_out (input_sync)
  );

  dkar_pulse #(.HALF_CYC(PULSE_HALF_CYC)) u_pulse (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (o3_mode == O3_PULSE),
    .req     (vol_tick && !count_stop),
    .level   (pulse_lvl)
  );

  // ahb-lite slave: writes take no wait state, reads one so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      wr_addr   <= 32'h0;
      rd_addr   <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      if (rd_pend)
        hreadyout <= 1'b1;
      if (hsel && htrans[1] && hready && addr_ok) begin
        wr_pend <= hwrite;
        rd_pend <= !hwrite;
        wr_addr <= haddr;
        rd_addr <= haddr;
        if (!hwrite)
          hreadyout <= 1'b0;
      end
    end
  end

  // read data, unmapped addresses read zero
  // everything readable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_pend) begin
      hrdata <= 32'h0;
      if (in_blk(rd_addr, A_DISP))
        hrdata <= {8'h00, disp_val(rd_addr[4:2])};
      else if (in_blk(rd_addr, A_CFG))
        hrdata <= {8'h00, cfg[rd_addr[4:2]]};
      else if (rd_addr == {24'h0, A_CTRL})
        hrdata <= ctrl;
      else if (rd_addr == {24'h0, A_STATUS})
        hrdata <= {8'h00, 1'b0, csel, 1'b0, sel, 3'h0, view, 4'h0,
                   count_stop, pi_manual, input_sync, alarm_lat};
      else if (rd_addr == {24'h0, A_ERR})
        hrdata <= {16'h0, lat_code, shown_code};
    end
  end

  // control word; bit zero is the level commanded for the digital output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctrl <= 32'h0;
    else if (wr_pend && wr_addr == {24'h0, A_CTRL})
      ctrl <= hwdata;
  end

  // configuration registers; the bus wins if keypad and bus hit in one cycle
  // equals overwrites
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++)
        cfg[i] <= CFG_RST;
    end else if (bw_cfg) begin
      cfg[bw_idx] <= hwdata[DW-1:0];
    end else if (kw_cfg) begin
      cfg[csel] <= entry;
    end
  end

  // writable display registers; measurements are inputs and ignore writes
  // equals writes shown register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spare          <= '0;
      setpoint_value <= '0;
    end else if (bw_disp && bw_idx == R_SPARE) begin
      spare <= hwdata[DW-1:0];
    end else if (bw_disp && bw_idx == R_SETPOINT_VALUE) begin
      setpoint_value <= hwdata[DW-1:0];
    end else if (kw_disp && sel == R_SPARE) begin
      spare <= entry;
    end else if (kw_disp && sel == R_SETPOINT_VALUE) begin
      setpoint_value <= entry;
    end
  end

  // totalizers: batch clear beats a preset, a preset beats counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      total_volume <= '0;
      batch_volume <= '0;
    end else begin
      if (bw_disp && bw_idx == R_TOTAL)
        total_volume <= hwdata[DW-1:0];
      else if (kw_disp && sel == R_TOTAL)
        total_volume <= entry;
      else if (vol_tick && !count_stop)
        total_volume <= total_volume + 1'b1;
      if (batch_edge)
        batch_volume <= '0;
      else if (bw_disp && bw_idx == R_BATCH)
        batch_volume <= hwdata[DW-1:0];
      else if (kw_disp && sel == R_BATCH)
        batch_volume <= entry;
      else if (vol_tick && !count_stop)
        batch_volume <= batch_volume + 1'b1;
    end
  end

  // logic input functions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_prev  <= 1'b0;
      batch_start <= 1'b0;
      pi_manual   <= 1'b0;
    end else begin
      input_prev  <= input_sync;
      batch_start <= batch_edge;
      pi_manual   <= (in_func == IF_MANUAL) && input_sync;
    end
  end

  // third output: exactly one of pulse, bus level or current loop drives it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_or_current_output <= 1'b0;
      out3_digital_en         <= 1'b1;
      current_loop_en         <= 1'b0;
      current_level           <= 16'h0000;
    end else begin
      out3_digital_en <= (o3_mode != O3_CURR);
      current_loop_en <= (o3_mode == O3_CURR);
      current_level   <= (o3_mode == O3_CURR) ? meas.instant[15:0] : 16'h0000;
      if (o3_mode == O3_BUS)
        pulse_or_current_output <= ctrl[CTRL_OUT3_LVL];
      else if (o3_mode == O3_PULSE)
        pulse_or_current_output <= pulse_lvl;
      else
        pulse_or_current_output <= 1'b0;
    end
  end

  // alarm latch: a present error re-latches at once, so set wins over the clear
  // the config picker ignores the test key, so it must not consume the latch there
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_lat  <= 1'b0;
      lat_code   <= 8'h00;
      shown_code <= 8'h00;
    end else if (k_take && key.code == KEY_TEST && view != V_CFGW) begin
      shown_code <= alarm_lat ? lat_code : err_code;
      alarm_lat  <= err_now;
      lat_code   <= err_code;
    end else if (err_now && !alarm_lat) begin
      alarm_lat <= 1'b1;
      lat_code  <= err_code;
    end
  end

  // one-second refresh divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_tmr  <= 32'h0;
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= (ref_tmr == 32'(REFRESH_CYC - 1));
      ref_tmr  <= (ref_tmr == 32'(REFRESH_CYC - 1)) ? 32'h0 : ref_tmr + 32'h1;
    end
  end

  // keypad view machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      view      <= V_SHOW;
      sel       <= R_FLOW;
      csel      <= 3'h0;
      entry     <= '0;
      entering  <= 1'b0;
      blank_tmr <= 32'h0;
      reload    <= 1'b1;
    end else begin
      reload <= k_take;
      unique case (view)
        V_BLANK: begin
          blank_tmr <= blank_tmr + 32'h1;
          if (blank_tmr == 32'(BLANK_CYC - 1)) begin
            view   <= V_SHOW;
            reload <= 1'b1;
          end
        end
        V_CFGW: begin
          if (k_digit && key.code != 5'h00 && key.code <= 5'h08) begin
            csel     <= 3'(key.code - 5'h01);
            view     <= V_CFG;
            entering <= 1'b0;
            entry    <= '0;
          end else if (k_sel) begin
            sel  <= key.code[2:0];
            view <= V_SHOW;
          end
        end
        default: begin
          if (k_sel) begin
            sel      <= key.code[2:0];
            view     <= V_SHOW;
            entering <= 1'b0;
          end else if (k_take && key.code == KEY_CFG) begin
            view     <= V_CFGW;
            entering <= 1'b0;
          end else if (k_take && key.code == KEY_TEST) begin
            view     <= V_ERR;
            entering <= 1'b0;
          end else if (k_digit && view != V_ERR) begin
            entry    <= {entry[DW-5:0], key.code[3:0]};
            entering <= 1'b1;
          end else if (kw_disp) begin
            view      <= V_BLANK;
            blank_tmr <= 32'h0;
            entering  <= 1'b0;
            entry     <= '0;
          end else if (kw_cfg) begin
            entering <= 1'b0;
            entry    <= '0;
          end
        end
      endcase
    end
  end

  // display frame; the config number holds the lead digit while that view is up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp <= '{update: 1'b0, blank: 1'b1, lead: CH_BLANK, value: '0};
    end else begin
      disp.update <= ref_tick || reload;
      disp.blank  <= (view == V_BLANK) || (view == V_CFGW);
      if (view == V_CFG)
        disp.lead <= CH_DIG1 + {5'h00, csel};
      else if (alarm_lat || err_now)
        disp.lead <= CH_ALARM;
      else
        disp.lead <= CH_BLANK;
      if (entering)
        disp.value <= entry;
      else if (view == V_CFG)
        disp.value <= cfg[csel];
      else if (view == V_ERR)
        disp.value <= {16'h0000, shown_code};
      else if (ref_tick || reload)
        disp.value <= disp_val(sel);
    end
  end
endmodule

// *** src/dkar_fix_note.sv ***
// intentionally empty

// *** sim/dkar_top_chk.sv ***
// concurrent checks on the ports of dkar_top
// assumes hready is wired to hreadyout on a one-slave bus
module dkar_top_chk
  import dkar_pkg::*;
#(
  parameter int BLANK_CYC   = 20,
  parameter int REFRESH_CYC = 16
) (
  // clock, reset and bus
  input wire logic                 hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  // display unit and function pins
  input wire dkar_pkg::dkar_key_t  key,
  input wire dkar_pkg::dkar_disp_t disp,
  input wire logic                 batch_start, pulse_or_current_output, out3_digital_en, current_loop_en,
  input wire logic [15:0]          current_level
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [31:0] gap;
  logic        go;
  assign go = hsel && htrans[1] && hready && haddr[1:0] == 2'h0;
  // cycles since the last refresh; a stuck refresh timer shows up here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      gap <= '0;
    else
      gap <= disp.update ? '0 : gap + 32'h1;
  end
  chk_mode_excl: assert property (!(out3_digital_en && current_loop_en))
    else $error("third output in two modes");
  chk_curr_idle: assert property (!current_loop_en |-> current_level == 16'h0000)
    else $error("current level outside current mode");
  chk_dig_quiet: assert property (current_loop_en |-> !pulse_or_current_output)
    else $error("digital level in current mode");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_read_wait: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_now: assert property (go && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_key_echo: assert property (key.valid && !disp.blank |-> ##2 disp.update)
    else $error("key without display update");
  chk_batch_once: assert property (batch_start |=> !batch_start)
    else $error("batch start longer than a cycle");
  chk_refresh_gap: assert property (gap <= REFRESH_CYC + BLANK_CYC + 2)
    else $error("display refresh missing");
endmodule
bind dkar_top dkar_top_chk #(.BLANK_CYC(BLANK_CYC), .REFRESH_CYC(REFRESH_CYC)) u_chk (.hclk, .hresetn, .hsel,
  .hwrite, .hready, .hreadyout, .hresp, .haddr, .htrans, .key, .disp, .batch_start, .pulse_or_current_output,
  .out3_digital_en, .current_loop_en, .current_level);

// *** sim/dkar_keypad_model.sv ***
// model of the local display/keypad unit: one key event per call
// assumes the caller sits just after a rising edge of hclk
module dkar_keypad_model
  import dkar_pkg::*;
(
  // clock and key event toward the transmitter
  input wire logic          hclk,
  output dkar_pkg::dkar_key_t key
);
  timeunit 1ns;
  timeprecision 1ns;
  initial key = '0;
  // one-cycle event, then a gap long enough for the new view to settle
  task automatic press(input logic [4:0] c);
    key <= '{valid: 1'b1, code: c};
    @(posedge hclk);
    // idle code is scrambled so nobody leans on a stale value
    key <= '{valid: 1'b0, code: ~c};
    repeat (3) @(posedge hclk);
  endtask
endmodule

// *** sim/dkar_top_bench.sv ***
// self-checking bench for dkar_top: ahb-lite tasks, keypad model, pin checks
// assumes the package, the keypad model and the checker are compiled first
module dkar_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dkar_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, vol_tick = 1'b0, inl = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, v;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h0;
  logic [7:0]  err_code = '0;
  logic        hreadyout, hresp, batch_start, pi_manual, o3, dig_en, cur_en;
  logic [15:0] cur_lvl;
  dkar_key_t   key;
  dkar_disp_t  disp;
  dkar_meas_t  meas = '0;
  logic [31:0] tbl [8] = '{32'h11, 32'h22, 32'h33, 32'h73, 32'h74, 32'h75, 32'h76, 32'h88};
  int          n_mismatch = 0, compares = 0, k;
  dkar_top #(.BLANK_CYC(20), .REFRESH_CYC(16), .PULSE_HALF_CYC(4)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .key, .disp, .meas, .vol_tick,
    .err_code, .logic_input_line(inl), .pulse_or_current_output(o3), .out3_digital_en(dig_en),
    .current_loop_en(cur_en), .current_level(cur_lvl), .batch_start, .pi_manual);
  dkar_keypad_model KP (.hclk, .key);
  initial begin
    forever #5 hclk = ~hclk;
  end
  task automatic close_out;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // single word transfer; each phase is held until ready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int j;
    j = 0;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (!hreadyout && ++j < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout && ++j < 50);
    rd = hrdata;
    if (j >= 50) begin
      n_mismatch++;
      close_out;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // a wait loop that used its whole bound is a failure, not a measurement
  task automatic lim(input int b);
    if (k >= b) begin
      n_mismatch++;
      close_out;
    end
  endtask
  task automatic tick;
    vol_tick <= 1'b1;
    @(posedge hclk);
    vol_tick <= 1'b0;
    cyc(2);
  endtask
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end
  initial begin
    cyc(6);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(8'h80, 1'b0, '0);
    ck(rd, '0);
    meas.instant <= 24'h00ABCD;
    // every third output mode, with the bus level set high
    for (int m = 0; m < 3; m++) begin
      xfer(A_CFG, 1'b1, {30'h0, m[1:0]});
      xfer(A_CTRL, 1'b1, 32'h1);
      cyc(3);
      ck({13'h0, dig_en, cur_en, cur_lvl, o3}, m == 2 ? {13'h0, 2'h1, 16'hABCD, 1'b0} : {14'h1, 17'h0, m == 1});
    end
    xfer(A_CFG, 1'b1, '0);
    tick;
    // wait for the pulse to show, then count its high cycles
    k = 0;
    while (!o3 && k < 50) begin
      @(posedge hclk);
      k++;
    end
    lim(50);
    k = 0;
    while (o3 && k < 50) begin
      @(posedge hclk);
      k++;
    end
    lim(50);
    ck(k, 32'h4);
    xfer(A_CFG, 1'b1, 32'h10);
    inl <= 1'b1;
    cyc(4);
    xfer(8'h30, 1'b0, '0);
    v = rd;
    tick;
    tick;
    xfer(8'h30, 1'b0, '0);
    ck(rd, v);
    inl <= 1'b0;
    cyc(4);
    tick;
    xfer(8'h30, 1'b0, '0);
    ck(rd, v + 32'h1);
    $display("done input modes");
    xfer(A_CFG, 1'b1, 32'h20);
    xfer(8'h34, 1'b1, 32'h5);
    inl <= 1'b1;
    k = 0;
    while (!batch_start && k < 20) begin
      @(posedge hclk);
      k++;
    end
    lim(20);
    ck({31'h0, batch_start}, 32'h1);
    cyc(3);
    xfer(8'h34, 1'b0, '0);
    ck(rd, '0);
    xfer(A_CFG, 1'b1, 32'h30);
    cyc(5);
    ck({31'h0, pi_manual}, 32'h1);
    inl <= 1'b0;
    cyc(5);
    ck({31'h0, pi_manual}, 32'h0);
    meas <= {24'h000011, 24'h000022, 24'h000033, 24'h000088};
    for (int i = 0; i < 8; i++)
      xfer(A_DISP + 8'(4 * i), 1'b1, 32'h70 + 32'(i));
    for (int i = 0; i < 8; i++) begin
      KP.press(KEY_SEL0 + 5'(i));
      ck({8'h0, disp.value}, tbl[i]);
    end
    KP.press(KEY_SEL0 + 5'h6);
    KP.press(5'h1);
    KP.press(5'h2);
    KP.press(5'h3);
    KP.press(KEY_EQ);
    ck({31'h0, disp.blank}, 32'h1);
    cyc(20);
    ck({7'h0, disp.blank, disp.value}, 32'h123);
    $display("done display registers");
    KP.press(KEY_CFG);
    ck({31'h0, disp.blank}, 32'h1);
    KP.press(5'h2);
    ck({24'h0, disp.lead}, {24'h0, CH_DIG1 + 8'h1});
    KP.press(5'h4);
    KP.press(5'h5);
    KP.press(KEY_EQ);
    cyc(25);
    xfer(A_CFG + 8'h4, 1'b0, '0);
    ck(rd, 32'h45);
    KP.press(KEY_SEL0);
    err_code <= 8'h27;
    cyc(20);
    ck({24'h0, disp.lead}, {24'h0, CH_ALARM});
    err_code <= 8'h00;
    cyc(20);
    ck({24'h0, disp.lead}, {24'h0, CH_ALARM});
    KP.press(KEY_TEST);
    ck({24'h0, disp.value[7:0]}, 32'h27);
    KP.press(KEY_TEST);
    ck({24'h0, disp.value[7:0]}, 32'h00);
    err_code <= 8'h55;
    cyc(20);
    ck({24'h0, disp.value[7:0]}, 32'h00);
    $display("done alarm readout");
    close_out;
  end
endmodule
